//--- verilog/pam_pkg.sv
// constants, types and register map of the product and sum move executor
package pam_pkg;
    // opcode upper bytes and fixed words
    localparam logic [7:0]  OP_STORE_HIGH = 8'h57;
    localparam logic [7:0]  OP_LOAD_MEM   = 8'h06;
    localparam logic [7:0]  OP_MOVE_PROD  = 8'h16;
    localparam logic [7:0]  OP_STORE_SUM  = 8'h1e;
    localparam logic [7:0]  OP_STORE_PROD = 8'ha9;
    localparam logic [15:0] OP_CC_STORE   = 16'h5648;
    localparam logic [3:0]  EXT_TOP       = 4'h0;
    // condition field codes
    localparam logic [3:0] CC_NEQ = 4'h0, CC_EQ = 4'h1, CC_GT = 4'h2, CC_GEQ = 4'h3;
    localparam logic [3:0] CC_LT = 4'h4, CC_LEQ = 4'h5, CC_HI = 4'h6, CC_HIS = 4'h7;
    localparam logic [3:0] CC_LO = 4'h8, CC_LOS = 4'h9, CC_NOV = 4'ha, CC_OV = 4'hb;
    localparam logic [3:0] CC_NTB = 4'hc, CC_TB = 4'hd, CC_NBP = 4'he, CC_UNC = 4'hf;
    // register byte offsets
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_FLAGS  = 12'h004;
    localparam logic [11:0] REG_SUM    = 12'h008;
    localparam logic [11:0] REG_PROD   = 12'h00c;
    localparam logic [11:0] REG_STATUS = 12'h010;
    // field positions
    localparam int F_N = 0;
    localparam int F_Z = 1;
    localparam int F_C = 2;
    localparam int F_V = 3;
    localparam int F_TB = 4;
    localparam int NFLAGS = 5;
    localparam int SHIFT_W = 4;
    localparam int ST_BUSY = 0;
    localparam int ST_CNT_LSB = 8;
    // reset values
    localparam logic [SHIFT_W-1:0] CTRL_RST = 4'h0;
    localparam logic [NFLAGS-1:0]  FLAGS_RST = 5'h00;
    localparam logic [31:0]        WORD_RST = 32'h0000_0000;
    // sequencer states
    typedef enum logic [1:0] {
        PAM_IDLE = 2'b01,
        PAM_EXEC = 2'b10
    } pam_state_t;
    // decoded operation kinds
    typedef enum logic [2:0] {
        K_NONE, K_STORE_HIGH, K_LOAD_MEM, K_MOVE_PROD,
        K_STORE_SUM, K_CC_STORE, K_STORE_PROD
    } pam_kind_t;
endpackage

//--- verilog/pam_exec.sv
// product and sum register move executor with apb register access
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ns
module pam_exec #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input  wire logic             CLK,
    input  wire logic             RST,
    // apb slave
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [11:0]      PADDR,
    input  wire logic [31:0]      PWDATA,
    output logic      [31:0]      PRDATA,
    output logic                  PREADY,
    output logic                  PSLVERR,
    // instruction stream
    input  wire logic             INSTR_VALID,
    input  wire logic [15:0]      INSTR_OP,
    input  wire logic [15:0]      INSTR_EXT,
    output logic                  INSTR_READY,
    output logic                  INSTR_DONE,
    // repeat prefix
    input  wire logic             REPEAT_PREFIX,
    input  wire logic [CNT_W-1:0] REPEAT_COUNT,
    // operand addressing unit
    output logic                  ADDR_REQ,
    output logic      [7:0]       ADDR_MODE,
    input  wire logic             LOC_SUM,
    input  wire logic             LOC_HALF_HI,
    input  wire logic             LOC_HALF_LO,
    input  wire logic             LOC_MULT,
    input  wire logic [31:0]      MEM_RDATA,
    // data memory write
    output logic                  MEM_WE,
    output logic                  MEM_WIDE,
    output logic      [31:0]      MEM_WDATA,
    // multiplicand load
    output logic                  MULT_WE,
    output logic      [15:0]      MULT_WDATA,
    // branch input pin
    input  wire logic             BRANCH_IN
);

    pam_pkg::pam_state_t            state_q;
    pam_pkg::pam_state_t            state_d;
    pam_pkg::pam_kind_t             kind_q;
    pam_pkg::pam_kind_t             kind_d;
    logic [3:0]                     cc_q;
    logic [CNT_W-1:0]               cnt_q;
    logic [31:0]                    sum_q;
    logic [31:0]                    prod_q;
    logic [pam_pkg::NFLAGS-1:0]     flags_q;
    logic [pam_pkg::SHIFT_W-1:0]    shift_q;
    logic                           bp_s1_q;
    logic                           bp_s2_q;
    logic                           pready_q;
    logic [31:0]                    prdata_q;
    logic                           pslverr_q;
    logic                           ready_q;
    logic                           done_q;
    logic                           areq_q;
    logic [7:0]                     amode_q;
    logic                           mwe_q;
    logic                           mwide_q;
    logic [31:0]                    mdata_q;
    logic                           twe_q;
    logic [15:0]                    tdata_q;
    logic                           accept;
    logic                           again;
    logic                           apb_fire;
    logic                           apb_wr;
    logic                           hit;
    logic [31:0]                    rd_mux;
    logic [31:0]                    shifted;
    logic                           cc_ok;
    logic                           ex_sum_we;
    logic [31:0]                    ex_sum;
    logic                           ex_nz_we;
    logic [31:0]                    ex_nz_src;
    logic                           ex_half;
    logic                           ex_v_clr;
    logic                           ex_mem_we;
    logic                           ex_mem_wide;
    logic [31:0]                    ex_mem_data;
    logic                           ex_t_we;

    // product shifted by a signed setting
    function automatic logic [31:0] shift_prod(input logic [31:0] p,
                                               input logic [3:0] s);
        logic [3:0] amt;
        amt = 4'h0;
        if (!s[3]) begin
            shift_prod = p << s; // low bits zero filled
        end else begin
            amt = 4'h0 - s;
            shift_prod = $unsigned($signed(p) >>> amt); // sign kept
        end
    endfunction

    assign shifted = shift_prod(prod_q, shift_q); // prod_q only read
    assign accept = INSTR_VALID & ready_q;
    assign again = (state_q == pam_pkg::PAM_EXEC) & (kind_q == pam_pkg::K_STORE_HIGH)
                 & (cnt_q != '0);

    // pin crosses into the core clock first
    always_ff @(posedge CLK) begin
        if (RST) begin
            bp_s1_q <= 1'b0;
            bp_s2_q <= 1'b0;
        end else begin
            bp_s1_q <= BRANCH_IN;
            bp_s2_q <= bp_s1_q;
        end
    end

    // condition evaluation over the flag set and the synchronised branch pin
    always_comb begin
        case (cc_q)
            pam_pkg::CC_NEQ: cc_ok = !flags_q[pam_pkg::F_Z];
            pam_pkg::CC_EQ:  cc_ok = flags_q[pam_pkg::F_Z];
            pam_pkg::CC_GT:  cc_ok = !flags_q[pam_pkg::F_Z] & !flags_q[pam_pkg::F_N];
            pam_pkg::CC_GEQ: cc_ok = !flags_q[pam_pkg::F_N];
            pam_pkg::CC_LT:  cc_ok = flags_q[pam_pkg::F_N];
            pam_pkg::CC_LEQ: cc_ok = flags_q[pam_pkg::F_Z] | flags_q[pam_pkg::F_N];
            pam_pkg::CC_HI:  cc_ok = flags_q[pam_pkg::F_C] & !flags_q[pam_pkg::F_Z];
            pam_pkg::CC_HIS: cc_ok = flags_q[pam_pkg::F_C];
            pam_pkg::CC_LO:  cc_ok = !flags_q[pam_pkg::F_C];
            pam_pkg::CC_LOS: cc_ok = !flags_q[pam_pkg::F_C] | flags_q[pam_pkg::F_Z];
            pam_pkg::CC_NOV: cc_ok = !flags_q[pam_pkg::F_V];
            pam_pkg::CC_OV:  cc_ok = flags_q[pam_pkg::F_V];
            pam_pkg::CC_NTB: cc_ok = !flags_q[pam_pkg::F_TB];
            pam_pkg::CC_TB:  cc_ok = flags_q[pam_pkg::F_TB];
            pam_pkg::CC_NBP: cc_ok = !bp_s2_q;
            default:         cc_ok = 1'b1;
        endcase
    end

    // opcode decode at acceptance
    always_comb begin
        kind_d = pam_pkg::K_NONE;
        if (INSTR_OP == pam_pkg::OP_CC_STORE && INSTR_EXT[15:12] == pam_pkg::EXT_TOP) begin
            kind_d = pam_pkg::K_CC_STORE;
        end else begin
            case (INSTR_OP[15:8])
                pam_pkg::OP_STORE_HIGH: kind_d = pam_pkg::K_STORE_HIGH;
                pam_pkg::OP_LOAD_MEM:   kind_d = pam_pkg::K_LOAD_MEM;
                pam_pkg::OP_MOVE_PROD:  kind_d = pam_pkg::K_MOVE_PROD; // alias shares it
                pam_pkg::OP_STORE_SUM:  kind_d = pam_pkg::K_STORE_SUM;
                pam_pkg::OP_STORE_PROD: kind_d = pam_pkg::K_STORE_PROD;
                default:                kind_d = pam_pkg::K_NONE;
            endcase
        end
    end

    // sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            pam_pkg::PAM_IDLE: begin
                if (accept) begin
                    state_d = pam_pkg::PAM_EXEC;
                end
            end
            pam_pkg::PAM_EXEC: begin
                if (!again) begin
                    state_d = pam_pkg::PAM_IDLE;
                end
            end
            default: state_d = pam_pkg::PAM_IDLE;
        endcase
    end

    // state, kind and condition held for the execute cycles
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= pam_pkg::PAM_IDLE;
            kind_q <= pam_pkg::K_NONE;
            cc_q <= 4'h0;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ready_q <= (state_d == pam_pkg::PAM_IDLE);
            if (accept) begin
                kind_q <= kind_d;
                cc_q <= INSTR_EXT[11:8];
            end
        end
    end

    // repeat counter: loaded by the prefix, consumed by one op
    always_ff @(posedge CLK) begin
        if (RST) begin
            cnt_q <= '0;
        end else if (accept && kind_d != pam_pkg::K_STORE_HIGH) begin
            cnt_q <= '0;
        end else if (again) begin
            cnt_q <= cnt_q - 1'b1; // N+1 passes in all
        end else if (REPEAT_PREFIX && ready_q) begin
            cnt_q <= REPEAT_COUNT;
        end
    end

    // one addressing request per pass, condition or not
    always_ff @(posedge CLK) begin
        if (RST) begin
            areq_q <= 1'b0;
            amode_q <= 8'h00;
        end else begin
            areq_q <= accept | again;
            if (accept) begin
                amode_q <= (kind_d == pam_pkg::K_CC_STORE) ? INSTR_EXT[7:0]
                                                           : INSTR_OP[7:0];
            end
        end
    end

    // execute: what each op does to the sum, flags and memory
    always_comb begin
        ex_sum_we = 1'b0;
        ex_sum = sum_q;
        ex_nz_we = 1'b0;
        ex_nz_src = sum_q;
        ex_half = 1'b0;
        ex_v_clr = 1'b0;
        ex_mem_we = 1'b0;
        ex_mem_wide = 1'b1;
        ex_mem_data = sum_q;
        ex_t_we = 1'b0;
        if (state_q == pam_pkg::PAM_EXEC) begin
            case (kind_q)
                pam_pkg::K_STORE_HIGH: begin
                    ex_nz_src = {16'h0000, shifted[31:16]};
                    ex_half = 1'b1;
                    if (LOC_HALF_HI || LOC_HALF_LO) begin
                        ex_sum_we = 1'b1;
                        ex_nz_we = 1'b1; // half tested at bit 15
                        ex_sum = LOC_HALF_HI ? {shifted[31:16], sum_q[15:0]}
                                             : {sum_q[31:16], shifted[31:16]};
                    end else begin
                        ex_mem_we = 1'b1;
                        ex_mem_wide = 1'b0;
                        ex_mem_data = {16'h0000, shifted[31:16]};
                    end
                end
                pam_pkg::K_LOAD_MEM: begin
                    ex_sum_we = 1'b1;
                    ex_sum = MEM_RDATA;
                    ex_nz_we = 1'b1;
                    ex_nz_src = MEM_RDATA;
                end
                pam_pkg::K_MOVE_PROD: begin
                    ex_sum_we = 1'b1;
                    ex_sum = shifted;
                    ex_nz_we = 1'b1;
                    ex_nz_src = shifted;
                    ex_t_we = !LOC_MULT; // multiplicand onto itself is a no-op
                end
                pam_pkg::K_STORE_SUM: begin
                    ex_nz_we = LOC_SUM;
                    ex_mem_we = !LOC_SUM;
                end
                pam_pkg::K_CC_STORE: begin
                    ex_nz_we = cc_ok & LOC_SUM;
                    ex_mem_we = cc_ok & !LOC_SUM;
                    ex_v_clr = (cc_q == pam_pkg::CC_NOV) | (cc_q == pam_pkg::CC_OV);
                end
                pam_pkg::K_STORE_PROD: begin
                    ex_sum_we = LOC_SUM;
                    ex_sum = prod_q;
                    ex_nz_we = LOC_SUM;
                    ex_nz_src = prod_q;
                    ex_mem_we = !LOC_SUM;
                    ex_mem_data = prod_q;
                end
                default: begin
                    ex_sum_we = 1'b0;
                end
            endcase
        end
    end

    // memory and multiplicand strobes, one cycle after each pass
    always_ff @(posedge CLK) begin
        if (RST) begin
            mwe_q <= 1'b0;
            mwide_q <= 1'b0;
            mdata_q <= pam_pkg::WORD_RST;
            twe_q <= 1'b0;
            tdata_q <= 16'h0000;
            done_q <= 1'b0;
        end else begin
            mwe_q <= ex_mem_we;
            twe_q <= ex_t_we;
            done_q <= (state_q == pam_pkg::PAM_EXEC) & !again;
            if (ex_mem_we) begin
                mwide_q <= ex_mem_wide;
                mdata_q <= ex_mem_data;
            end
            if (ex_t_we) begin
                tdata_q <= MEM_RDATA[15:0];
            end
        end
    end

    // apb handshake: one wait state, answer registered
    assign apb_fire = PSEL & PENABLE & pready_q;
    assign apb_wr = apb_fire & PWRITE & !pslverr_q;
    assign hit = (PADDR == pam_pkg::REG_CTRL) | (PADDR == pam_pkg::REG_FLAGS)
               | (PADDR == pam_pkg::REG_SUM) | (PADDR == pam_pkg::REG_PROD)
               | (PADDR == pam_pkg::REG_STATUS);

    // read mux, unused bits as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (PADDR)
            pam_pkg::REG_CTRL:  rd_mux[pam_pkg::SHIFT_W-1:0] = shift_q;
            pam_pkg::REG_FLAGS: rd_mux[pam_pkg::NFLAGS-1:0] = flags_q;
            pam_pkg::REG_SUM:   rd_mux = sum_q;
            pam_pkg::REG_PROD:  rd_mux = prod_q;
            pam_pkg::REG_STATUS: begin
                rd_mux[pam_pkg::ST_BUSY] = !ready_q;
                rd_mux[pam_pkg::ST_CNT_LSB +: CNT_W] = cnt_q;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            pready_q <= 1'b0;
            prdata_q <= pam_pkg::WORD_RST;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= PSEL & PENABLE & !pready_q;
            if (PSEL && PENABLE && !pready_q) begin
                prdata_q <= PWRITE ? 32'h0000_0000 : rd_mux;
                pslverr_q <= !hit | (PWRITE & (PADDR == pam_pkg::REG_STATUS));
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // shift setting written by software only
    always_ff @(posedge CLK) begin
        if (RST) begin
            shift_q <= pam_pkg::CTRL_RST;
        end else if (apb_wr && PADDR == pam_pkg::REG_CTRL) begin
            shift_q <= PWDATA[pam_pkg::SHIFT_W-1:0];
        end
    end

    // product: software seed only, moves never write it
    always_ff @(posedge CLK) begin
        if (RST) begin
            prod_q <= pam_pkg::WORD_RST;
        end else if (apb_wr && PADDR == pam_pkg::REG_PROD) begin
            prod_q <= PWDATA;
        end
    end

    // sum register: execution wins over a software write
    always_ff @(posedge CLK) begin
        if (RST) begin
            sum_q <= pam_pkg::WORD_RST;
        end else if (ex_sum_we) begin
            sum_q <= ex_sum;
        end else if (apb_wr && PADDR == pam_pkg::REG_SUM) begin
            sum_q <= PWDATA;
        end
    end

    // flags: hardware update wins so no result is lost
    always_ff @(posedge CLK) begin
        if (RST) begin
            flags_q <= pam_pkg::FLAGS_RST;
        end else begin
            if (apb_wr && PADDR == pam_pkg::REG_FLAGS) begin
                flags_q <= PWDATA[pam_pkg::NFLAGS-1:0];
            end
            if (ex_nz_we) begin
                flags_q[pam_pkg::F_N] <= ex_half ? ex_nz_src[15] : ex_nz_src[31];
                flags_q[pam_pkg::F_Z] <= ex_half ? (ex_nz_src[15:0] == 16'h0000)
                                                 : (ex_nz_src == 32'h0000_0000);
            end
            if (ex_v_clr) begin
                flags_q[pam_pkg::F_V] <= 1'b0;
            end
        end
    end

    // outputs straight from flops
    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign INSTR_READY = ready_q;
    assign INSTR_DONE = done_q;
    assign ADDR_REQ = areq_q;
    assign ADDR_MODE = amode_q;
    assign MEM_WE = mwe_q;
    assign MEM_WIDE = mwide_q;
    assign MEM_WDATA = mdata_q;
    assign MULT_WE = twe_q;
    assign MULT_WDATA = tdata_q;

endmodule

//--- verification/pam_mem_model.sv
// addressing unit and data memory model facing the move executor
`timescale 1ns/1ns
module pam_mem_model (
    // clock and requests
    input wire logic        clk,
    input wire logic        addr_req,
    input wire logic [7:0]  addr_mode,
    input wire logic        mem_we,
    input wire logic [31:0] mem_wdata,
    // answers
    output logic            loc_sum,
    output logic            loc_half_hi,
    output logic            loc_half_lo,
    output logic            loc_mult,
    output logic [31:0]     mem_rdata
);
    logic [31:0] mem [0:255];
    logic [31:0] last_q = '0;
    logic [31:0] wr_data;
    int          req_cnt = 0;
    int          wr_cnt = 0;
    // mode 00 is the sum register, 01/02 its halves, ac the multiplicand
    assign loc_sum = addr_req && addr_mode == 8'h00;
    assign loc_half_hi = addr_req && addr_mode == 8'h01;
    assign loc_half_lo = addr_req && addr_mode == 8'h02;
    assign loc_mult = addr_req && addr_mode == 8'hac;
    // idle bus toggles so a late sample never sees the old word
    assign mem_rdata = addr_req ? mem[addr_mode] : ~last_q;
    // one pointer step per pass, counted even for a false condition
    always @(posedge clk) begin
        last_q <= mem_rdata;
        req_cnt <= req_cnt + addr_req;
        wr_cnt <= wr_cnt + mem_we;
        if (mem_we)
            wr_data <= mem_wdata;
    end
endmodule

//--- verification/pam_exec_monitor.sv
// concurrent checks on the move executor ports
`timescale 1ns/1ns
module pam_exec_monitor (
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // instruction and addressing side
    input wire logic        INSTR_VALID,
    input wire logic [15:0] INSTR_OP,
    input wire logic [15:0] INSTR_EXT,
    input wire logic        INSTR_READY,
    input wire logic        INSTR_DONE,
    input wire logic        ADDR_REQ,
    input wire logic [7:0]  ADDR_MODE,
    input wire logic        LOC_SUM,
    input wire logic        LOC_HALF_HI,
    input wire logic        LOC_HALF_LO,
    input wire logic        LOC_MULT,
    // write strobes
    input wire logic        MEM_WE,
    input wire logic        MEM_WIDE,
    input wire logic        MULT_WE
);
    logic [7:0] up_q;
    logic       cs_q;
    logic [3:0] cc_q;
    wire        take = INSTR_VALID && INSTR_READY;
    wire        ext = !LOC_SUM && !LOC_HALF_HI && !LOC_HALF_LO;
    wire        ld = INSTR_OP[15:8] == 8'h06;
    wire        sng = ld || INSTR_OP[15:8] == 8'h1e || INSTR_OP[15:8] == 8'ha9;
    wire        cnd = INSTR_OP == pam_pkg::OP_CC_STORE && INSTR_EXT[15:12] == 4'h0;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // keep the taken opcode, the input words move on before execute
    always_ff @(posedge CLK) begin
        if (take) begin
            up_q <= INSTR_OP[15:8];
            cs_q <= cnd;
            cc_q <= INSTR_EXT[11:8];
        end
    end
    property p_mode; take && sng |=> ADDR_REQ && ADDR_MODE == $past(INSTR_OP[7:0]); endproperty
    a_mode: assert property (p_mode) else $error("operand byte lost");
    property p_once; take && ld |=> ADDR_REQ ##1 !ADDR_REQ && INSTR_DONE; endproperty
    a_once: assert property (p_once) else $error("load ran twice");
    property p_load; take && ld |=> !MEM_WE [*2]; endproperty
    a_load: assert property (p_load) else $error("load wrote memory");
    property p_high; ADDR_REQ && up_q == 8'h57 && ext |=> MEM_WE && !MEM_WIDE; endproperty
    a_high: assert property (p_high) else $error("high word store missing");
    property p_sum; ADDR_REQ && up_q == 8'h1e && ext |=> MEM_WE && MEM_WIDE; endproperty
    a_sum: assert property (p_sum) else $error("sum store missing");
    property p_prod; ADDR_REQ && up_q == 8'ha9 && ext |=> MEM_WE && MEM_WIDE; endproperty
    a_prod: assert property (p_prod) else $error("product store missing");
    property p_mult; ADDR_REQ && up_q == 8'h16 && LOC_MULT |=> !MULT_WE && !MEM_WE; endproperty
    a_mult: assert property (p_mult) else $error("shifted load wrote out");
    property p_ptr; take && cnd |=> ADDR_REQ ##1 INSTR_DONE; endproperty
    a_ptr: assert property (p_ptr) else $error("no pointer pass");
    property p_unc; ADDR_REQ && cs_q && cc_q == 4'hf && ext |=> MEM_WE; endproperty
    a_unc: assert property (p_unc) else $error("always store skipped");
    c_condition_field: cover property (take && cnd);
    c_rep: cover property (ADDR_REQ [*3]);
    c_half: cover property (ADDR_REQ && LOC_HALF_HI);
endmodule

bind pam_exec pam_exec_monitor u_mon (
    .CLK, .RST, .INSTR_VALID, .INSTR_OP, .INSTR_EXT, .INSTR_READY, .INSTR_DONE, .ADDR_REQ, .ADDR_MODE,
    .LOC_SUM, .LOC_HALF_HI, .LOC_HALF_LO, .LOC_MULT, .MEM_WE, .MEM_WIDE, .MULT_WE
);

//--- verification/pam_exec_tb_top.sv
// self-checking bench for the product and sum move executor
`timescale 1ns/1ns
module pam_exec_tb_top;
    logic        CLK = 1'h0, RST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
    logic        INSTR_VALID = 1'h0, REPEAT_PREFIX = 1'h0, BRANCH_IN = 1'h0, err;
    logic        PREADY, PSLVERR, INSTR_READY, INSTR_DONE, ADDR_REQ, MEM_WE, MEM_WIDE, MULT_WE;
    logic        LOC_SUM, LOC_HALF_HI, LOC_HALF_LO, LOC_MULT;
    logic [11:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, MEM_RDATA, MEM_WDATA, rd, e;
    logic [15:0] INSTR_OP = '0, INSTR_EXT = '0, MULT_WDATA;
    logic [7:0]  REPEAT_COUNT = '0, ADDR_MODE;
    int          miscompares = 0, cmp_count = 0, cycles = 0, w0, q0;

    pam_exec #(.CNT_W(8)) dut (
        .CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
        .INSTR_VALID, .INSTR_OP, .INSTR_EXT, .INSTR_READY, .INSTR_DONE, .REPEAT_PREFIX, .REPEAT_COUNT,
        .ADDR_REQ, .ADDR_MODE, .LOC_SUM, .LOC_HALF_HI, .LOC_HALF_LO, .LOC_MULT, .MEM_RDATA,
        .MEM_WE, .MEM_WIDE, .MEM_WDATA, .MULT_WE, .MULT_WDATA, .BRANCH_IN
    );
    pam_mem_model mdl (
        .clk(CLK), .addr_req(ADDR_REQ), .addr_mode(ADDR_MODE), .mem_we(MEM_WE), .mem_wdata(MEM_WDATA),
        .loc_sum(LOC_SUM), .loc_half_hi(LOC_HALF_HI), .loc_half_lo(LOC_HALF_LO), .loc_mult(LOC_MULT),
        .mem_rdata(MEM_RDATA)
    );

    // clock, and a ceiling well above the expected run length
    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            $display("[ERR] %0t timeout", $time);
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, request held until ready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'h1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'h1;
        do @(posedge CLK); while (PREADY !== 1'h1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] x);
        apb(1'h0, a, '0);
        chk(rd, x);
    endtask
    // offer one instruction, then wait for its completion pulse
    task automatic run(input logic [15:0] op, input logic [15:0] ex);
        @(posedge CLK);
        INSTR_VALID <= 1'h1;
        INSTR_OP <= op;
        INSTR_EXT <= ex;
        do @(posedge CLK); while (INSTR_READY !== 1'h1);
        INSTR_VALID <= 1'h0;
        do @(posedge CLK); while (INSTR_DONE !== 1'h1);
        @(posedge CLK);
    endtask
    task automatic pfx(input logic [7:0] n);
        @(posedge CLK);
        REPEAT_PREFIX <= 1'h1;
        REPEAT_COUNT <= n;
        @(posedge CLK);
        REPEAT_PREFIX <= 1'h0;
    endtask
    // signed shift setting: left zero-filled, right sign-extended
    function automatic logic [31:0] shp(input logic [31:0] p, input logic [3:0] s);
        if (s[3])
            return $signed(p) >>> (4'h0 - s);
        return p << s;
    endfunction
    // condition table, flags n z c v tc in bits 0..4
    function automatic logic cnd(input logic [3:0] c, input logic [4:0] f, input logic b);
        logic [15:0] t;
        t = {1'h1, !b, f[4], !f[4], f[3], !f[3], !f[2] || f[1], !f[2], f[2], f[2] && !f[1],
             f[1] || f[0], f[0], !f[0], !f[1] && !f[0], f[1], !f[1]};
        return t[c];
    endfunction

    // main sequence
    initial begin
        mdl.mem[8'h10] = 32'h8000_0000;
        mdl.mem[8'h11] = '0;
        mdl.mem[8'h12] = 32'h0000_5a5a;
        repeat (6) @(posedge CLK);
        RST <= 1'h0;
        for (int i = 0; i < 5; i++) rchk(12'(i * 4), '0);
        rchk(12'h014, '0);
        chk({31'h0, err}, 32'h1);
        run(16'h0610, '0);
        rchk(pam_pkg::REG_SUM, 32'h8000_0000);
        rchk(pam_pkg::REG_FLAGS, 32'h1);
        pfx(8'h03);
        q0 = mdl.req_cnt;
        run(16'h0611, '0);
        chk(mdl.req_cnt - q0, 1);
        rchk(pam_pkg::REG_STATUS, '0);
        rchk(pam_pkg::REG_FLAGS, 32'h2);
        // high word store, left then right shift, three passes each
        apb(1'h1, pam_pkg::REG_PROD, 32'h8765_4321);
        for (int s = 4; s < 16; s += 8) begin
            apb(1'h1, pam_pkg::REG_CTRL, 32'(s));
            pfx(8'h02);
            w0 = mdl.wr_cnt;
            run(16'h5720, '0);
            e = shp(32'h8765_4321, 4'(s));
            chk(mdl.wr_cnt - w0, 3);
            chk({16'h0, mdl.wr_data[15:0]}, {16'h0, e[31:16]});
        end
        rchk(pam_pkg::REG_PROD, 32'h8765_4321);
        run(16'h5701, '0);
        rchk(pam_pkg::REG_SUM, {e[31:16], 16'h0});
        run(16'h5702, '0);
        rchk(pam_pkg::REG_SUM, {2{e[31:16]}});
        rchk(pam_pkg::REG_FLAGS, 32'h1);
        apb(1'h1, pam_pkg::REG_CTRL, 32'h4);
        run(16'h16ac, '0);
        rchk(pam_pkg::REG_SUM, shp(32'h8765_4321, 4'h4));
        rchk(pam_pkg::REG_FLAGS, '0);
        run(16'h1612, '0);
        chk({16'h0, MULT_WDATA}, 32'h5a5a);
        run(16'h1e20, '0);
        chk(mdl.wr_data, 32'h7654_3210);
        run(16'ha900, '0);
        rchk(pam_pkg::REG_SUM, 32'h8765_4321);
        rchk(pam_pkg::REG_FLAGS, 32'h1);
        run(16'ha930, '0);
        chk(mdl.wr_data, 32'h8765_4321);
        // every condition code with all flags clear, then all set
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 16; c++) begin
                BRANCH_IN <= p[0];
                e = {27'h0, {5{p[0]}}};
                apb(1'h1, pam_pkg::REG_FLAGS, e);
                w0 = mdl.wr_cnt;
                q0 = mdl.req_cnt;
                run(pam_pkg::OP_CC_STORE, {4'h0, 4'(c), 8'h40});
                chk(mdl.wr_cnt - w0, cnd(4'(c), e[4:0], p[0]));
                chk(mdl.req_cnt - q0, 1);
                if (c == 10 || c == 11)
                    e[3] = 1'h0;
                rchk(pam_pkg::REG_FLAGS, e);
            end
        end
        apb(1'h1, pam_pkg::REG_FLAGS, '0);
        run(pam_pkg::OP_CC_STORE, 16'h0f00);
        rchk(pam_pkg::REG_FLAGS, 32'h1);
        tally_and_finish();
    end
endmodule
